//--- hdl/jsra_pkg.sv
package jsra_pkg;

	// ------------------------------------------------------------
	// scan geometry
	// ------------------------------------------------------------
	localparam int IR_BITS   = 8;
	localparam int ADDR_BITS = 7;
	localparam int ROW_BITS  = 16;
	localparam int ROW_COUNT = 96;
	localparam int DR_BITS   = ROW_BITS + ADDR_BITS;
	localparam int PAT_BITS  = DR_BITS + 5;

	// ------------------------------------------------------------
	// instruction codes, bit 7 is the last bit shifted
	// ------------------------------------------------------------
	localparam logic [IR_BITS-1:0] OP_OPEN    = 8'h8b;
	localparam logic [IR_BITS-1:0] OP_WRITE   = 8'hb3;
	localparam logic [IR_BITS-1:0] OP_READ    = 8'hf3;
	localparam logic [IR_BITS-1:0] OP_CLOSE   = 8'h81;
	localparam logic [IR_BITS-1:0] OP_BYPASS  = 8'hff;
	localparam logic [IR_BITS-1:0] IR_CAPTURE = 8'h01;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS  = 4000;
	localparam int TCK_HALF_CLKS  = 8;
	localparam int TCK_PERIOD_PS  = 2 * TCK_HALF_CLKS * CLK_PERIOD_PS;
	localparam int RESET_TCKS     = 5;
	localparam int FINISH_TCKS    = 3;
	localparam int OPEN_WAIT_US   = 800;
	localparam int OPEN_WAIT_TCKS =
		(OPEN_WAIT_US * 1000000 + TCK_PERIOD_PS - 1) / TCK_PERIOD_PS;

	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	typedef enum logic [15:0] {
		TAP_RESET = 16'h0001, TAP_IDLE  = 16'h0002, TAP_SELDR = 16'h0004,
		TAP_CAPDR = 16'h0008, TAP_SHDR  = 16'h0010, TAP_EX1DR = 16'h0020,
		TAP_PAUDR = 16'h0040, TAP_EX2DR = 16'h0080, TAP_UPDDR = 16'h0100,
		TAP_SELIR = 16'h0200, TAP_CAPIR = 16'h0400, TAP_SHIR  = 16'h0800,
		TAP_EX1IR = 16'h1000, TAP_PAUIR = 16'h2000, TAP_EX2IR = 16'h4000,
		TAP_UPDIR = 16'h8000
	} jsra_tap_t;

	typedef enum logic [8:0] {
		SEQ_IDLE = 9'h001, SEQ_RST  = 9'h002, SEQ_OPEN = 9'h004,
		SEQ_WAIT = 9'h008, SEQ_OP   = 9'h010, SEQ_ROW  = 9'h020,
		SEQ_DIS  = 9'h040, SEQ_BYP  = 9'h080, SEQ_FIN  = 9'h100
	} jsra_seq_t;

endpackage

//--- hdl/jsra_link_if.sv
`timescale 1ns/100ps
interface jsra_link_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;

	modport prog (output tck, output tms, output tdi, input tdo);
	modport dev (input tck, input tms, input tdi, output tdo);
endinterface

//--- hdl/jsra_dev.sv
// Overview of operation
// - programmer holds mode select high five clocks
// - eight-bit instruction, top bit on exit edge
// - access-enable instruction opens configuration access
// - update-IR loads instruction, sets enable flop
// - programmer idles 800 us after enable
// - write instruction makes scans write rows
// - write scan: data, then address, stored
// - seven-bit address, bit 0 on exit
// - read: equalize, transfer row, load shifter
// - programmer repeats row scan 96 times
// - disable instruction executes on next idle
// - disable leaves access, applies nonvolatile array
// - bypass instruction loaded at update-IR
// - three high clocks to reset, user mode
// - programmer follows enable-op-rows-disable-bypass order
// - read instruction makes scans read rows
// - previous row shifted out, first bit early
`timescale 1ns/100ps
module jsra_dev
	import jsra_pkg::*;
(
	// system
	input  wire logic                clock,
	input  wire logic                rst_n,
	// link
	jsra_link_if.dev                 link,
	// user side
	input  wire logic [ADDR_BITS-1:0] user_row_addr,
	output logic      [ROW_BITS-1:0]  user_row_data,
	output logic                      access_active,
	output logic                      user_mode,
	output logic                      nv_apply
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic tck_s1_ff;
	logic tck_s2_ff;
	logic tck_s3_ff;
	logic tms_s1_ff;
	logic tms_s2_ff;
	logic tdi_s1_ff;
	logic tdi_s2_ff;
	logic step;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tck_s1_ff <= 1'b0;
			tck_s2_ff <= 1'b0;
			tck_s3_ff <= 1'b0;
			tms_s1_ff <= 1'b1;
			tms_s2_ff <= 1'b1;
			tdi_s1_ff <= 1'b1;
			tdi_s2_ff <= 1'b1;
		end else begin
			tck_s1_ff <= link.tck;
			tck_s2_ff <= tck_s1_ff;
			tck_s3_ff <= tck_s2_ff;
			tms_s1_ff <= link.tms;
			tms_s2_ff <= tms_s1_ff;
			tdi_s1_ff <= link.tdi;
			tdi_s2_ff <= tdi_s1_ff;
		end
	end

	assign step = tck_s2_ff & ~tck_s3_ff;

	// ------------------------------------------------------------
	// port controller
	// ------------------------------------------------------------
	jsra_tap_t tap_ff;
	jsra_tap_t nxt_tap;

	always_comb begin
		case (tap_ff)
			TAP_RESET: nxt_tap = tms_s2_ff ? TAP_RESET : TAP_IDLE;
			TAP_IDLE:  nxt_tap = tms_s2_ff ? TAP_SELDR : TAP_IDLE;
			TAP_SELDR: nxt_tap = tms_s2_ff ? TAP_SELIR : TAP_CAPDR;
			TAP_CAPDR: nxt_tap = tms_s2_ff ? TAP_EX1DR : TAP_SHDR;
			TAP_SHDR:  nxt_tap = tms_s2_ff ? TAP_EX1DR : TAP_SHDR;
			TAP_EX1DR: nxt_tap = tms_s2_ff ? TAP_UPDDR : TAP_PAUDR;
			TAP_PAUDR: nxt_tap = tms_s2_ff ? TAP_EX2DR : TAP_PAUDR;
			TAP_EX2DR: nxt_tap = tms_s2_ff ? TAP_UPDDR : TAP_SHDR;
			TAP_UPDDR: nxt_tap = tms_s2_ff ? TAP_SELDR : TAP_IDLE;
			TAP_SELIR: nxt_tap = tms_s2_ff ? TAP_RESET : TAP_CAPIR;
			TAP_CAPIR: nxt_tap = tms_s2_ff ? TAP_EX1IR : TAP_SHIR;
			TAP_SHIR:  nxt_tap = tms_s2_ff ? TAP_EX1IR : TAP_SHIR;
			TAP_EX1IR: nxt_tap = tms_s2_ff ? TAP_UPDIR : TAP_PAUIR;
			TAP_PAUIR: nxt_tap = tms_s2_ff ? TAP_EX2IR : TAP_PAUIR;
			TAP_EX2IR: nxt_tap = tms_s2_ff ? TAP_UPDIR : TAP_SHIR;
			TAP_UPDIR: nxt_tap = tms_s2_ff ? TAP_SELDR : TAP_IDLE;
			default:   nxt_tap = TAP_RESET;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tap_ff <= TAP_RESET;
		end else if (step) begin
			tap_ff <= nxt_tap;
		end
	end

	// ------------------------------------------------------------
	// instruction register
	// ------------------------------------------------------------
	logic [IR_BITS-1:0] ir_sr_ff;
	logic [IR_BITS-1:0] ir_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ir_sr_ff <= IR_CAPTURE;
		end else if (step && tap_ff == TAP_CAPIR) begin
			ir_sr_ff <= IR_CAPTURE;
		end else if (step && tap_ff == TAP_SHIR) begin
			ir_sr_ff <= {tdi_s2_ff, ir_sr_ff[IR_BITS-1:1]};
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ir_ff <= OP_BYPASS;
		end else if (step && nxt_tap == TAP_RESET) begin
			ir_ff <= OP_BYPASS;
		end else if (step && nxt_tap == TAP_UPDIR) begin
			ir_ff <= ir_sr_ff;
		end
	end

	// ------------------------------------------------------------
	// access mode and user mode
	// ------------------------------------------------------------
	logic access_ff;
	logic user_mode_ff;
	logic nv_apply_ff;
	logic close_exec;

	assign close_exec = step && tap_ff == TAP_IDLE && ir_ff == OP_CLOSE && access_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			access_ff <= 1'b0;
		end else if (step && nxt_tap == TAP_UPDIR && ir_sr_ff == OP_OPEN) begin
			access_ff <= 1'b1;
		end else if (close_exec) begin
			access_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			nv_apply_ff <= 1'b0;
		end else begin
			nv_apply_ff <= close_exec;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			user_mode_ff <= 1'b1;
		end else if (access_ff) begin
			user_mode_ff <= 1'b0;
		end else if (step && nxt_tap == TAP_RESET) begin
			user_mode_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// configuration rows
	// ------------------------------------------------------------
	logic [ROW_BITS-1:0]  mem_ff [ROW_COUNT];
	logic [DR_BITS-1:0]   dr_sr_ff;
	logic [ROW_BITS-1:0]  bitline_ff;
	logic                 bypass_ff;
	logic                 wr_mode;
	logic                 rd_mode;
	logic                 sram_mode;
	logic [ADDR_BITS-1:0] dr_addr;

	assign wr_mode   = access_ff && ir_ff == OP_WRITE;
	assign rd_mode   = access_ff && ir_ff == OP_READ;
	assign sram_mode = wr_mode | rd_mode;
	assign dr_addr   = dr_sr_ff[ADDR_BITS-1:0];

	function automatic logic [ROW_BITS-1:0] row_at(input logic [ADDR_BITS-1:0] a);
		logic [ROW_BITS-1:0] r;
		r = '1;
		for (int i = 0; i < ROW_COUNT; i++) begin
			if (a == ADDR_BITS'(i)) begin
				r = mem_ff[i];
			end
		end
		return r;
	endfunction

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < ROW_COUNT; i++) begin
				mem_ff[i] <= '1;
			end
		end else if (step && nxt_tap == TAP_UPDDR && wr_mode) begin
			for (int i = 0; i < ROW_COUNT; i++) begin
				if (dr_addr == ADDR_BITS'(i)) begin
					mem_ff[i] <= dr_sr_ff[DR_BITS-1:ADDR_BITS];
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bitline_ff <= '1;
		end else if (step && nxt_tap == TAP_EX1DR && rd_mode) begin
			bitline_ff <= '1;
		end else if (step && nxt_tap == TAP_UPDDR && rd_mode) begin
			bitline_ff <= row_at(dr_addr);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dr_sr_ff <= '1;
		end else if (step && tap_ff == TAP_SHDR && sram_mode) begin
			dr_sr_ff <= {dr_sr_ff[DR_BITS-2:0], tdi_s2_ff};
		end else if (step && tap_ff == TAP_UPDDR && nxt_tap == TAP_IDLE && rd_mode) begin
			dr_sr_ff <= {bitline_ff, {ADDR_BITS{1'b0}}};
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bypass_ff <= 1'b0;
		end else if (step && tap_ff == TAP_CAPDR) begin
			bypass_ff <= 1'b0;
		end else if (step && tap_ff == TAP_SHDR) begin
			bypass_ff <= tdi_s2_ff;
		end
	end

	// ------------------------------------------------------------
	// serial output and user read port
	// ------------------------------------------------------------
	logic                tdo_ff;
	logic [ROW_BITS-1:0] user_row_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tdo_ff <= 1'b1;
		end else if (tap_ff == TAP_SHIR) begin
			tdo_ff <= ir_sr_ff[0];
		end else if (tap_ff == TAP_SHDR) begin
			tdo_ff <= sram_mode ? dr_sr_ff[DR_BITS-1] : bypass_ff;
		end else begin
			tdo_ff <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			user_row_ff <= '1;
		end else begin
			user_row_ff <= row_at(user_row_addr);
		end
	end

	assign link.tdo      = tdo_ff;
	assign user_row_data = user_row_ff;
	assign access_active = access_ff;
	assign user_mode     = user_mode_ff;
	assign nv_apply      = nv_apply_ff;
endmodule // jsra_dev

//--- hdl/jsra_prog.sv
`timescale 1ns/100ps
module jsra_prog
	import jsra_pkg::*;
#(
	parameter int OPEN_WAIT = OPEN_WAIT_TCKS
)(
	// system
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	// link
	jsra_link_if.prog                 link,
	// command
	input  wire logic                 start,
	input  wire logic                 read_sel,
	output logic                      busy,
	output logic                      done,
	// row data
	output logic      [ADDR_BITS-1:0] wr_row_addr,
	input  wire logic [ROW_BITS-1:0]  wr_row_data,
	output logic                      rd_valid,
	output logic      [ADDR_BITS-1:0] rd_row_addr,
	output logic      [ROW_BITS-1:0]  rd_row_data
);

	// ------------------------------------------------------------
	// test clock divider and output sampling
	// ------------------------------------------------------------
	logic [3:0] div_ff;
	logic       tck_ff;
	logic       tick;
	logic       fall;
	logic       rise;
	logic       tdo_s1_ff;
	logic       tdo_s2_ff;

	assign tick = div_ff == 4'(TCK_HALF_CLKS - 1);
	assign fall = tick & tck_ff;
	assign rise = tick & ~tck_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_ff    <= 4'h0;
			tck_ff    <= 1'b0;
			tdo_s1_ff <= 1'b1;
			tdo_s2_ff <= 1'b1;
		end else begin
			div_ff    <= tick ? 4'h0 : div_ff + 4'h1;
			tck_ff    <= tick ? ~tck_ff : tck_ff;
			tdo_s1_ff <= link.tdo;
			tdo_s2_ff <= tdo_s1_ff;
		end
	end

	// ------------------------------------------------------------
	// phase patterns, first bit in bit 0
	// ------------------------------------------------------------
	function automatic logic [PAT_BITS-1:0] ir_tdi(input logic [IR_BITS-1:0] op);
		return PAT_BITS'({op, 4'h0});
	endfunction

	function automatic logic [PAT_BITS-1:0] dr_tdi(input logic [ROW_BITS-1:0] d,
		input logic [ADDR_BITS-1:0] a);
		logic [DR_BITS-1:0]  v;
		logic [PAT_BITS-1:0] p;
		v = {d, a};
		p = '0;
		for (int k = 0; k < DR_BITS; k++) begin
			p[3+k] = v[DR_BITS-1-k];
		end
		return p;
	endfunction

	localparam logic [PAT_BITS-1:0] IR_TMS  = PAT_BITS'(14'h1803);
	localparam logic [PAT_BITS-1:0] DR_TMS  = PAT_BITS'(3'h1) | (PAT_BITS'(3'h3) << (DR_BITS + 2));
	localparam logic [PAT_BITS-1:0] RST_TMS = PAT_BITS'((1 << RESET_TCKS) - 1);
	localparam logic [7:0]          IR_LEN  = 8'd14;
	localparam logic [7:0]          DR_LEN  = 8'(PAT_BITS);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	jsra_seq_t             seq_ff;
	jsra_seq_t             nxt_seq;
	logic [PAT_BITS-1:0]   tms_pat_ff;
	logic [PAT_BITS-1:0]   tdi_pat_ff;
	logic [PAT_BITS-1:0]   ld_tms;
	logic [PAT_BITS-1:0]   ld_tdi;
	logic [7:0]            ld_len;
	logic [7:0]            len_ff;
	logic [7:0]            idx_ff;
	logic [15:0]           wait_ff;
	logic [ADDR_BITS-1:0]  row_ff;
	logic                  req_ff;
	logic                  rdm_ff;
	logic                  tms_ff;
	logic                  tdi_ff;
	logic                  load;
	logic [ROW_BITS-1:0]   row_data;

	assign load     = fall && len_ff == 8'h0;
	assign row_data = rdm_ff ? '0 : wr_row_data;

	always_comb begin
		nxt_seq = seq_ff;
		ld_tms  = '1;
		ld_tdi  = '0;
		ld_len  = 8'h1;
		case (seq_ff)
			SEQ_IDLE: begin
				if (req_ff) begin
					nxt_seq = SEQ_RST;
					ld_tms  = RST_TMS;
					ld_len  = 8'(RESET_TCKS + 1);
				end
			end
			SEQ_RST: begin
				nxt_seq = SEQ_OPEN;
				ld_tms  = IR_TMS;
				ld_tdi  = ir_tdi(OP_OPEN);
				ld_len  = IR_LEN;
			end
			SEQ_OPEN, SEQ_WAIT: begin
				nxt_seq = SEQ_WAIT;
				ld_tms  = '0;
				if (seq_ff == SEQ_WAIT && wait_ff == 16'h0) begin
					nxt_seq = SEQ_OP;
					ld_tms  = IR_TMS;
					ld_tdi  = ir_tdi(rdm_ff ? OP_READ : OP_WRITE);
					ld_len  = IR_LEN;
				end
			end
			SEQ_OP, SEQ_ROW: begin
				nxt_seq = SEQ_ROW;
				ld_tms  = DR_TMS;
				ld_tdi  = dr_tdi(row_data, row_ff);
				ld_len  = DR_LEN;
				if (seq_ff == SEQ_ROW && row_ff == ADDR_BITS'(ROW_COUNT)) begin
					nxt_seq = SEQ_DIS;
					ld_tms  = IR_TMS;
					ld_tdi  = ir_tdi(OP_CLOSE);
					ld_len  = IR_LEN;
				end
			end
			SEQ_DIS: begin
				nxt_seq = SEQ_BYP;
				ld_tms  = IR_TMS;
				ld_tdi  = ir_tdi(OP_BYPASS);
				ld_len  = IR_LEN - 8'h1;
			end
			SEQ_BYP: begin
				nxt_seq = SEQ_FIN;
				ld_len  = 8'(FINISH_TCKS);
			end
			SEQ_FIN: begin
				nxt_seq = SEQ_IDLE;
			end
			default: begin
				nxt_seq = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			seq_ff     <= SEQ_IDLE;
			tms_pat_ff <= '1;
			tdi_pat_ff <= '0;
			len_ff     <= 8'h0;
			idx_ff     <= 8'h0;
			tms_ff     <= 1'b1;
			tdi_ff     <= 1'b0;
		end else if (load) begin
			seq_ff     <= nxt_seq;
			tms_ff     <= ld_tms[0];
			tdi_ff     <= ld_tdi[0];
			tms_pat_ff <= ld_tms >> 1;
			tdi_pat_ff <= ld_tdi >> 1;
			len_ff     <= (seq_ff == SEQ_IDLE && !req_ff) ? 8'h0 : ld_len - 8'h1;
			idx_ff     <= 8'h0;
		end else if (fall) begin
			tms_ff     <= tms_pat_ff[0];
			tdi_ff     <= tdi_pat_ff[0];
			tms_pat_ff <= tms_pat_ff >> 1;
			tdi_pat_ff <= tdi_pat_ff >> 1;
			len_ff     <= len_ff - 8'h1;
			idx_ff     <= idx_ff + 8'h1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			req_ff <= 1'b0;
			rdm_ff <= 1'b0;
		end else if (start && seq_ff == SEQ_IDLE && !req_ff) begin
			req_ff <= 1'b1;
			rdm_ff <= read_sel;
		end else if (load && seq_ff == SEQ_IDLE) begin
			req_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wait_ff <= 16'h0;
			row_ff  <= '0;
		end else if (load && seq_ff == SEQ_OPEN) begin
			wait_ff <= 16'(OPEN_WAIT - 2);
			row_ff  <= '0;
		end else if (load && seq_ff == SEQ_WAIT) begin
			wait_ff <= wait_ff - 16'h1;
		end else if (load && nxt_seq == SEQ_ROW) begin
			row_ff  <= row_ff + 7'h1;
		end
	end

	// ------------------------------------------------------------
	// read back, previous scan's row on each pass after the first
	// ------------------------------------------------------------
	logic [ROW_BITS-1:0]  rd_sr_ff;
	logic                 rd_valid_ff;
	logic [ADDR_BITS-1:0] rd_addr_ff;
	logic [ROW_BITS-1:0]  rd_data_ff;
	logic                 done_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_sr_ff <= '1;
		end else if (rise && seq_ff == SEQ_ROW && idx_ff >= 8'd3 &&
			idx_ff < 8'(3 + ROW_BITS)) begin
			rd_sr_ff <= {rd_sr_ff[ROW_BITS-2:0], tdo_s2_ff};
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid_ff <= 1'b0;
			rd_addr_ff  <= '0;
			rd_data_ff  <= '0;
			done_ff     <= 1'b0;
		end else begin
			rd_valid_ff <= load && seq_ff == SEQ_ROW && rdm_ff && row_ff >= 7'h2;
			done_ff     <= load && seq_ff == SEQ_FIN;
			if (load && seq_ff == SEQ_ROW) begin
				rd_addr_ff <= row_ff - 7'h2;
				rd_data_ff <= rd_sr_ff;
			end
		end
	end

	assign link.tck    = tck_ff;
	assign link.tms    = tms_ff;
	assign link.tdi    = tdi_ff;
	assign busy        = req_ff | (seq_ff != SEQ_IDLE);
	assign done        = done_ff;
	assign wr_row_addr = row_ff;
	assign rd_valid    = rd_valid_ff;
	assign rd_row_addr = rd_addr_ff;
	assign rd_row_data = rd_data_ff;

endmodule // jsra_prog

//--- sim/jsra_chk.sv
`timescale 1ns/100ps
module jsra_chk
	import jsra_pkg::*;
#(
	parameter int OPEN_WAIT = OPEN_WAIT_TCKS
)(
	// system
	input wire logic clock,
	input wire logic rst_n,
	// link
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo
);
	// ------------------------------------------------
	// port state tracker
	// ------------------------------------------------
	function automatic jsra_tap_t tap_next(jsra_tap_t s, logic m);
		case (s)
			TAP_RESET: return m ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: return m ? TAP_SELDR : TAP_IDLE;
			TAP_SELDR: return m ? TAP_SELIR : TAP_CAPDR;
			TAP_CAPDR, TAP_SHDR: return m ? TAP_EX1DR : TAP_SHDR;
			TAP_EX1DR: return m ? TAP_UPDDR : TAP_PAUDR;
			TAP_EX2IR: return m ? TAP_UPDIR : TAP_SHIR;
			TAP_PAUDR: return m ? TAP_EX2DR : TAP_PAUDR;
			TAP_EX2DR: return m ? TAP_UPDDR : TAP_SHDR;
			TAP_SELIR: return m ? TAP_RESET : TAP_CAPIR;
			TAP_CAPIR, TAP_SHIR: return m ? TAP_EX1IR : TAP_SHIR;
			TAP_EX1IR: return m ? TAP_UPDIR : TAP_PAUIR;
			TAP_PAUIR: return m ? TAP_EX2IR : TAP_PAUIR;
			default: return m ? TAP_SELDR : TAP_IDLE;
		endcase
	endfunction

	logic               tck_ff;
	logic               rise;
	jsra_tap_t          tap_ff;
	logic [IR_BITS-1:0] ir_ff;
	logic [7:0]         bits_ff;
	logic [3:0]         hi_ff;
	logic [15:0]        wait_ff;

	assign rise = tck & ~tck_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tck_ff <= 1'b0;
			tap_ff <= TAP_RESET;
			ir_ff <= 8'h00;
		end else begin
			tck_ff <= tck;
			if (rise) tap_ff <= tap_next(tap_ff, tms);
			if (rise && tap_ff == TAP_SHIR) ir_ff <= {tdi, ir_ff[IR_BITS-1:1]};
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bits_ff <= 8'h00;
			hi_ff <= 4'h0;
			wait_ff <= 16'h0000;
		end else if (rise) begin
			if (tap_ff == TAP_CAPIR || tap_ff == TAP_CAPDR) bits_ff <= 8'h00;
			else if (tap_ff == TAP_SHIR || tap_ff == TAP_SHDR) bits_ff <= bits_ff + 8'h01;
			hi_ff <= !tms ? 4'h0 : (hi_ff == 4'hf ? hi_ff : hi_ff + 4'h1);
			if (tap_ff == TAP_UPDIR) wait_ff <= 16'h0000;
			else if (tap_ff == TAP_IDLE) wait_ff <= wait_ff + 16'h0001;
		end
	end

	// ------------------------------------------------
	// link checks
	// ------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_tms_steady: assert property (tck |-> $stable(tms) && $stable(tdi))
		else $error("mode select or data moved while test clock high");
	a_tdo_released: assert property (rise && tap_ff != TAP_SHIR && tap_ff != TAP_SHDR |-> tdo)
		else $error("serial output not high outside shift");
	a_five_high: assert property (rise && tap_ff == TAP_RESET && !tms |-> hi_ff >= RESET_TCKS)
		else $error("left test reset too early");
	a_ir_length: assert property (rise && tap_ff == TAP_SHIR && tms |-> bits_ff == IR_BITS - 1)
		else $error("instruction length wrong");
	a_dr_length: assert property (rise && tap_ff == TAP_SHDR && tms |-> bits_ff == DR_BITS - 1)
		else $error("row scan length wrong");
	a_open_wait: assert property (rise && tap_ff == TAP_IDLE && tms && ir_ff == OP_OPEN
		|-> wait_ff >= OPEN_WAIT - 1)
		else $error("idle after enable too short");
	a_close_idle: assert property (rise && tap_ff == TAP_UPDIR && ir_ff == OP_CLOSE |-> !tms)
		else $error("no idle clock after disable");
	a_finish_tms: assert property (rise && tap_ff == TAP_UPDIR && ir_ff == OP_BYPASS
		|-> tms ##16 (rise && tms) ##16 (rise && tms))
		else $error("finish not three high clocks");
endmodule // jsra_chk

//--- sim/jsra_sram_row_access_tb_top.sv
`timescale 1ns/100ps
module jtag_sram_row_access_tb_top
	import jsra_pkg::*;
;
	localparam int OPEN_W = 4;

	logic                 clock;
	logic                 rst_n;
	logic                 start;
	logic                 read_sel;
	logic [ADDR_BITS-1:0] user_row_addr;
	logic [ROW_BITS-1:0]  wr_row_data;
	logic [ROW_BITS-1:0]  user_row_data;
	logic                 access_active;
	logic                 user_mode;
	logic                 nv_apply;
	logic                 busy;
	logic                 done;
	logic [ADDR_BITS-1:0] wr_row_addr;
	logic                 rd_valid;
	logic [ADDR_BITS-1:0] rd_row_addr;
	logic [ROW_BITS-1:0]  rd_row_data;
	logic [ROW_BITS-1:0]  row_tab [0:ROW_COUNT-1];
	logic [DR_BITS-1:0]   dr_sh;
	logic [ROW_BITS-1:0]  tdo_sh;
	logic                 mode_rd;
	int                   seed;
	int                   err_total;
	int                   compares;
	int                   n_ir;
	int                   n_dr;
	int                   n_bit;
	int                   n_rd;
	int                   n_nv;

	jsra_link_if link_a ();
	jsra_dev i_jsra_dev (.clock(clock), .rst_n(rst_n), .link(link_a.dev),
		.user_row_addr(user_row_addr), .user_row_data(user_row_data),
		.access_active(access_active), .user_mode(user_mode), .nv_apply(nv_apply));
	jsra_prog #(.OPEN_WAIT(OPEN_W)) i_jsra_prog (.clock(clock), .rst_n(rst_n),
		.link(link_a.prog), .start(start), .read_sel(read_sel), .busy(busy), .done(done),
		.wr_row_addr(wr_row_addr), .wr_row_data(wr_row_data), .rd_valid(rd_valid),
		.rd_row_addr(rd_row_addr), .rd_row_data(rd_row_data));
	jsra_chk #(.OPEN_WAIT(OPEN_W)) i_jsra_chk (.clock(clock), .rst_n(rst_n),
		.tck(link_a.tck), .tms(link_a.tms), .tdi(link_a.tdi), .tdo(link_a.tdo));

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [IR_BITS-1:0] exp_op(int k, logic rd);
		case (k)
			0: return OP_OPEN;
			1: return rd ? OP_READ : OP_WRITE;
			2: return OP_CLOSE;
			default: return OP_BYPASS;
		endcase
	endfunction

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic run_seq(input logic rd);
		int n;
		n = 0;
		mode_rd = rd;
		n_ir = 0;
		n_dr = 0;
		n_rd = 0;
		n_nv = 0;
		@(posedge clock);
		start <= 1'b1;
		read_sel <= rd;
		@(posedge clock);
		start <= 1'b0;
		@(negedge clock);
		check("busy", busy, 1'b1);
		while (done !== 1'b1 && n < 50000) begin
			@(negedge clock);
			n++;
		end
		check("done", done, 1'b1);
		repeat (32) @(negedge clock);
		check("user_mode", user_mode, 1'b1);
		check("busy_end", busy, 1'b0);
		check("access", access_active, 1'b0);
		check("nv_pulses", n_nv, 1);
		check("ir_count", n_ir, 4);
		check("row_scans", n_dr, ROW_COUNT);
		check("rd_reports", n_rd, rd ? ROW_COUNT - 1 : 0);
	endtask

	task automatic peek_rows();
		logic [ADDR_BITS-1:0] a;
		for (int i = 0; i < 8; i++) begin
			a = (i == 0) ? 7'h00 : (i == 1) ? 7'h5f : (i == 2) ? 7'h60 : 7'($random(seed));
			@(posedge clock);
			user_row_addr <= a;
			@(posedge clock);
			@(negedge clock);
			check("user_row", user_row_data, a < ROW_COUNT ? row_tab[a] : 16'hffff);
		end
	endtask

	// ------------------------------------------------
	// monitors
	// ------------------------------------------------
	always @(posedge clock) begin
		wr_row_data <= wr_row_addr < ROW_COUNT ? row_tab[wr_row_addr] : 16'hffff;
		if (nv_apply === 1'b1) n_nv++;
		if (rd_valid === 1'b1) begin
			check("rd_addr", rd_row_addr, n_rd);
			check("rd_data", rd_row_data, row_tab[rd_row_addr]);
			n_rd++;
		end
	end

	always @(posedge clock) begin
		if (rst_n && i_jsra_chk.rise) begin
			case (i_jsra_chk.tap_ff)
				TAP_CAPDR: n_bit = 0;
				TAP_SHDR: begin
					if (n_bit < ROW_BITS) tdo_sh = {tdo_sh[ROW_BITS-2:0], link_a.tdo};
					dr_sh = {dr_sh[DR_BITS-2:0], link_a.tdi};
					n_bit++;
				end
				TAP_UPDIR: begin
					check("opcode", i_jsra_chk.ir_ff, exp_op(n_ir, mode_rd));
					n_ir++;
				end
				TAP_UPDDR: begin
					check("dr_bits", n_bit, DR_BITS);
					check("row_addr", dr_sh[ADDR_BITS-1:0], n_dr);
					check("access", {user_mode, access_active}, 2'b01);
					if (mode_rd && n_dr > 0) check("tdo_row", tdo_sh, row_tab[n_dr-1]);
					if (!mode_rd) check("row_data", dr_sh[DR_BITS-1:ADDR_BITS], row_tab[n_dr]);
					n_dr++;
				end
				default: ;
			endcase
		end
	end

	// ------------------------------------------------
	// clock, main sequence, watchdog
	// ------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	initial begin
		seed = 81751;
		err_total = 0;
		compares = 0;
		start = 1'b0;
		read_sel = 1'b0;
		user_row_addr = 7'h00;
		wr_row_data = 16'h0000;
		mode_rd = 1'b0;
		rst_n = 1'b0;
		for (int i = 0; i < ROW_COUNT; i++) row_tab[i] = 16'($random(seed));
		row_tab[0] = 16'h0000;
		row_tab[1] = 16'hffff;
		row_tab[ROW_COUNT-1] = 16'h8001;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock);
		check("reset_row", user_row_data, 16'hffff);
		check("reset_mode", user_mode, 1'b1);
		run_seq(1'b0);
		peek_rows();
		run_seq(1'b1);
		give_verdict();
	end

	initial begin
		repeat (99000) @(posedge clock);
		err_total++;
		give_verdict();
	end
endmodule // jtag_sram_row_access_tb_top
